// ===== logic/dtp_pkg.sv
// Shared constants, mode enumeration and decode for the dual 8-bit timer pair
package dtp_pkg;
	// Counter geometry and values
	localparam int CNT_W = 8;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CMP_DFLT = 8'h00;
	// Register selects on the register port
	localparam logic [2:0] SEL_CMP_A = 3'h0;
	localparam logic [2:0] SEL_CMP_B = 3'h1;
	localparam logic [2:0] SEL_HW_B = 3'h2;
	localparam logic [2:0] SEL_CNT_A = 3'h3;
	localparam logic [2:0] SEL_CNT_B = 3'h4;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// Mode bit patterns {mode_a_hi, mode_a_lo, mode_b_hi, mode_b_lo}
	localparam logic [3:0] MB_DISCRETE = 4'h0;
	localparam logic [3:0] MB_CASCADE = 4'h5;
	localparam logic [3:0] MB_CARRIER = 4'h3;
	localparam logic [3:0] MB_A_DISC_B_PWM = 4'h2;
	localparam logic [3:0] MB_BOTH_PWM = 4'hA;
	localparam logic [3:0] MB_A_PWM_B_DISC = 4'h8;

	// Decoded operating modes
	typedef enum logic [2:0] {
		MD_DISCRETE = 3'b000,
		MD_CASCADE = 3'b001,
		MD_CARRIER = 3'b010,
		MD_A_DISC_B_PWM = 3'b011,
		MD_BOTH_PWM = 3'b100,
		MD_A_PWM_B_DISC = 3'b101,
		MD_PROHIBITED = 3'b110
	} dtp_mode_e;

	// Map the four mode bits onto a mode; anything else is prohibited
	function automatic dtp_mode_e dtp_decode_mode(input logic [3:0] bits);
		case (bits)
			MB_DISCRETE: dtp_decode_mode = MD_DISCRETE;
			MB_CASCADE: dtp_decode_mode = MD_CASCADE;
			MB_CARRIER: dtp_decode_mode = MD_CARRIER;
			MB_A_DISC_B_PWM: dtp_decode_mode = MD_A_DISC_B_PWM;
			MB_BOTH_PWM: dtp_decode_mode = MD_BOTH_PWM;
			MB_A_PWM_B_DISC: dtp_decode_mode = MD_A_PWM_B_DISC;
			default: dtp_decode_mode = MD_PROHIBITED;
		endcase
	endfunction : dtp_decode_mode
endpackage : dtp_pkg

// ===== logic/dtp_cnt_if.sv
// Control and count bundle between the timer core and one counter
`timescale 1ns/1ps
interface dtp_cnt_if #(parameter int W = 8) ();
	logic inc; // Advance by one
	logic clr; // Clear to zero, wins over inc
	logic [W-1:0] count; // Present count
	modport ctl (output inc, output clr, input count);
	modport cnt (input inc, input clr, output count);
endinterface : dtp_cnt_if

// ===== logic/dtp_sync_edge.sv
// Two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module dtp_sync_edge (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic async_in,
	output logic rise_out,
	output logic fall_out
);
	// Whole state in one struct
	typedef struct packed {
		logic s1; // First stage, read only by s2
		logic s2; // Second stage, safe to use
		logic prev; // Last settled level
		logic rise; // One-cycle pulses
		logic fall;
	} dtp_edge_s;

	dtp_edge_s st_r;
	dtp_edge_s st_nxt;

	// Shift and compare settled levels only
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = async_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		st_nxt.rise = st_r.s2 && !st_r.prev;
		st_nxt.fall = !st_r.s2 && st_r.prev;
		if (srst_in) begin
			st_nxt = '0;
		end
	end

	// State register
	always_ff @(posedge clk_sys_in) begin
		st_r <= st_nxt;
	end

	assign rise_out = st_r.rise;
	assign fall_out = st_r.fall;
endmodule : dtp_sync_edge

// ===== logic/dtp_counter.sv
// Plain up-counter with clear priority, driven through the counter bundle
`timescale 1ns/1ps
module dtp_counter #(
	parameter int W = 8
) (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	dtp_cnt_if.cnt cif
);
	// Refuse a width the logic cannot hold
	if (W < 2) begin : g_chk
		$error("dtp_counter width must be at least two");
	end

	// Whole state in one struct
	typedef struct packed {
		logic [W-1:0] count;
	} dtp_cnt_s;

	dtp_cnt_s st_r;
	dtp_cnt_s st_nxt;

	// Clear beats increment; the max value wraps to zero on its own
	always_comb begin
		st_nxt = st_r;
		if (srst_in || cif.clr) begin
			st_nxt.count = '0;
		end else if (cif.inc) begin
			st_nxt.count = st_r.count + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// State register
	always_ff @(posedge clk_sys_in) begin
		st_r <= st_nxt;
	end

	assign cif.count = st_r.count;
endmodule : dtp_counter

// ===== logic/dtp_top.sv
// Dual 8-bit timer pair: modes, compare logic, outputs and register port
`timescale 1ns/1ps
module dtp_top (
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic count_clk_a_in,
	input wire logic count_clk_b_in,
	input wire logic run_a_in,
	input wire logic run_b_in,
	input wire logic dual_edge_a_in,
	input wire logic mode_a_hi_in,
	input wire logic mode_a_lo_in,
	input wire logic mode_b_hi_in,
	input wire logic mode_b_lo_in,
	input wire logic out_en_a_in,
	input wire logic out_en_b0_in,
	input wire logic out_en_b1_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [2:0] reg_sel_in,
	input wire logic [dtp_pkg::CNT_W-1:0] reg_wdata_in,
	output logic [dtp_pkg::CNT_W-1:0] reg_rdata_out,
	output logic out_a_out,
	output logic out_b0_out,
	output logic out_b1_out,
	output logic irq_a_out,
	output logic irq_b_out
);
	import dtp_pkg::*;

	// Whole block state in one struct
	typedef struct packed {
		logic [CNT_W-1:0] cmp_a; // match_a
		logic [CNT_W-1:0] cmp_b; // match_b
		logic [CNT_W-1:0] hw_b; // high_width_b
		logic [CNT_W-1:0] rdata; // Read data latch
		logic tog_a; // Timer A output state, carrier gate
		logic tog_b; // Timer B output state, carrier phase
		logic pin_a; // Registered pins
		logic pin_b0;
		logic pin_b1;
		logic irq_a; // One-cycle requests
		logic irq_b;
	} dtp_top_s;

	dtp_top_s st_r;
	dtp_top_s st_nxt;

	// Counter bundles
	dtp_cnt_if #(.W(CNT_W)) cif_a ();
	dtp_cnt_if #(.W(CNT_W)) cif_b ();

	// Edge pulses from the count clock pins
	logic rise_a;
	logic fall_a;
	logic rise_b;

	// Mode and compare helpers
	dtp_mode_e mode;
	logic is_casc;
	logic is_carr;
	logic pwm_a;
	logic pwm_b;
	logic legal;
	logic run_a_eff;
	logic run_b_eff;
	logic tick_a;
	logic tick_b;
	logic eq_a;
	logic eq_b;
	logic eq_h;
	logic max_a;
	logic max_b;
	logic b_sig; // Timer B signal before pin routing

	// Pins are asynchronous, so each goes through a synchroniser
	dtp_sync_edge u_edge_a (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.async_in(count_clk_a_in),
		.rise_out(rise_a),
		.fall_out(fall_a)
	);

	dtp_sync_edge u_edge_b (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.async_in(count_clk_b_in),
		.rise_out(rise_b),
		.fall_out()
	);

	// Timer A counter
	dtp_counter #(.W(CNT_W)) u_cnt_a (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.cif(cif_a.cnt)
	);

	// Timer B counter, also the event counter
	dtp_counter #(.W(CNT_W)) u_cnt_b (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.cif(cif_b.cnt)
	);

	// Mode decode; a prohibited pattern holds both timers stopped
	assign mode = dtp_decode_mode({mode_a_hi_in, mode_a_lo_in, mode_b_hi_in, mode_b_lo_in});
	assign is_casc = (mode == MD_CASCADE);
	assign is_carr = (mode == MD_CARRIER);
	assign pwm_a = (mode == MD_BOTH_PWM) || (mode == MD_A_PWM_B_DISC);
	assign pwm_b = (mode == MD_BOTH_PWM) || (mode == MD_A_DISC_B_PWM);
	assign legal = (mode != MD_PROHIBITED);

	// In cascade only run_b counts; run_a is ignored
	assign run_a_eff = legal && (is_casc ? run_b_in : run_a_in);
	assign run_b_eff = legal && run_b_in;

	// Falling edges count only for A in PWM
	assign tick_a = rise_a || (pwm_a && dual_edge_a_in && fall_a);
	assign tick_b = rise_b;

	// Continuous comparators
	assign eq_a = (cif_a.count == st_r.cmp_a);
	assign eq_b = (cif_b.count == st_r.cmp_b);
	assign eq_h = (cif_b.count == st_r.hw_b);
	assign max_a = (cif_a.count == CNT_MAX);
	assign max_b = (cif_b.count == CNT_MAX);

	// Next state: counting, toggles, pins, registers
	always_comb begin
		st_nxt = st_r;
		cif_a.inc = 1'b0;
		cif_a.clr = 1'b0;
		cif_b.inc = 1'b0;
		cif_b.clr = 1'b0;
		st_nxt.irq_a = 1'b0;
		st_nxt.irq_b = 1'b0;
		b_sig = 1'b0;

		// Timer A, and the joint counter in cascade
		if (!run_a_eff) begin
			// Stop clears the count and parks the output low
			cif_a.clr = 1'b1;
			st_nxt.tog_a = 1'b0;
		end else if (is_casc) begin
			if (tick_b) begin
				if (eq_a && eq_b) begin
					// Joint match clears both, only irq_b fires
					cif_a.clr = 1'b1;
					cif_b.clr = 1'b1;
					st_nxt.irq_b = 1'b1;
					st_nxt.tog_b = !st_r.tog_b;
				end else begin
					// B carry clocks A; joint overflow wraps both to zero
					cif_b.inc = 1'b1;
					cif_a.inc = max_b;
				end
			end
		end else if (tick_a) begin
			if (eq_a) begin
				// Match clears in every non-cascade mode
				cif_a.clr = 1'b1;
				st_nxt.irq_a = 1'b1;
				st_nxt.tog_a = !st_r.tog_a;
			end else if (max_a) begin
				// Overflow clears; in PWM it also toggles
				cif_a.clr = 1'b1;
				if (pwm_a) begin
					st_nxt.tog_a = !st_r.tog_a;
				end
			end else begin
				cif_a.inc = 1'b1;
			end
		end

		// Timer B: stop in every mode, counting outside cascade
		if (!run_b_eff) begin
			cif_b.clr = 1'b1;
			st_nxt.tog_b = 1'b0;
		end else if (!is_casc && tick_b) begin
			if (is_carr) begin
				// Low phase ends on match_b, high phase on high_width_b
				if ((!st_r.tog_b && eq_b) || (st_r.tog_b && eq_h)) begin
					cif_b.clr = 1'b1;
					st_nxt.tog_b = !st_r.tog_b;
				end else if (max_b) begin
					cif_b.clr = 1'b1;
				end else begin
					cif_b.inc = 1'b1;
				end
				st_nxt.irq_b = eq_b;
			end else if (pwm_b) begin
				if (eq_h) begin
					// Width compare ends the high level and the period
					cif_b.clr = 1'b1;
					st_nxt.tog_b = 1'b0;
				end else if (max_b) begin
					cif_b.clr = 1'b1;
					st_nxt.tog_b = 1'b0;
				end else begin
					cif_b.inc = 1'b1;
					if (eq_b) begin
						st_nxt.tog_b = 1'b1;
						st_nxt.irq_b = 1'b1;
					end
				end
			end else begin
				if (eq_b) begin
					cif_b.clr = 1'b1;
					st_nxt.irq_b = 1'b1;
					st_nxt.tog_b = !st_r.tog_b;
				end else if (max_b) begin
					cif_b.clr = 1'b1;
				end else begin
					cif_b.inc = 1'b1;
				end
			end
		end

		// Carrier is gated by timer A's output state
		b_sig = is_carr ? (st_nxt.tog_b && st_nxt.tog_a) : st_nxt.tog_b;

		// Pins registered so the outputs come straight from flops
		st_nxt.pin_a = out_en_a_in && st_nxt.tog_a;
		st_nxt.pin_b0 = out_en_b0_in && b_sig;
		st_nxt.pin_b1 = out_en_b1_in && b_sig;

		// Byte writes to compare registers; counters are read-only
		if (reg_wr_in) begin
			case (reg_sel_in)
				SEL_CMP_A: st_nxt.cmp_a = reg_wdata_in;
				SEL_CMP_B: st_nxt.cmp_b = reg_wdata_in;
				SEL_HW_B: st_nxt.hw_b = reg_wdata_in;
				default: st_nxt.cmp_a = st_r.cmp_a;
			endcase
		end

		// Byte reads latch one cycle after the strobe
		if (reg_rd_in) begin
			case (reg_sel_in)
				SEL_CMP_A: st_nxt.rdata = st_r.cmp_a;
				SEL_CMP_B: st_nxt.rdata = st_r.cmp_b;
				SEL_HW_B: st_nxt.rdata = st_r.hw_b;
				SEL_CNT_A: st_nxt.rdata = cif_a.count;
				SEL_CNT_B: st_nxt.rdata = cif_b.count;
				default: st_nxt.rdata = RD_UNMAPPED;
			endcase
		end

		// Reset clears all but the compare registers, which keep whatever they hold
		if (srst_in) begin
			st_nxt = '0;
			st_nxt.cmp_a = st_r.cmp_a;
			st_nxt.cmp_b = st_r.cmp_b;
			st_nxt.hw_b = st_r.hw_b;
		end
	end

	// State register
	always_ff @(posedge clk_sys_in) begin
		st_r <= st_nxt;
	end

	// Outputs
	assign reg_rdata_out = st_r.rdata;
	assign out_a_out = st_r.pin_a;
	assign out_b0_out = st_r.pin_b0;
	assign out_b1_out = st_r.pin_b1;
	assign irq_a_out = st_r.irq_a;
	assign irq_b_out = st_r.irq_b;

	// Cascade never raises irq_a
	property p_casc_no_irq_a;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_casc && $past(is_casc)) |-> !irq_a_out;
	endproperty
	a_casc_no_irq_a: assert property (p_casc_no_irq_a) else $error("irq_a in cascade");

	// A stopped timer reads zero next cycle
	property p_stop_clears;
		@(posedge clk_sys_in) disable iff (srst_in)
		!run_a_eff |=> (cif_a.count == CNT_RST);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("count_a not cleared");

	// Discrete match on B raises irq_b and clears B
	property p_irq_b_match;
		@(posedge clk_sys_in) disable iff (srst_in)
		(mode == MD_DISCRETE && run_b_eff && tick_b && eq_b)
			|=> (irq_b_out && cif_b.count == CNT_RST);
	endproperty
	a_irq_b_match: assert property (p_irq_b_match) else $error("irq_b missing");

	// Match on A outside cascade raises irq_a
	property p_irq_a_match;
		@(posedge clk_sys_in) disable iff (srst_in)
		(!is_casc && run_a_eff && tick_a && eq_a) |=> irq_a_out;
	endproperty
	a_irq_a_match: assert property (p_irq_a_match) else $error("irq_a missing");

	// Joint match in cascade clears both counters
	property p_casc_clear;
		@(posedge clk_sys_in) disable iff (srst_in)
		(is_casc && run_b_eff && tick_b && eq_a && eq_b)
			|=> (cif_a.count == CNT_RST && cif_b.count == CNT_RST && irq_b_out);
	endproperty
	a_casc_clear: assert property (p_casc_clear) else $error("cascade clear failed");

	// A running discrete count steps by exactly one
	property p_count_step;
		@(posedge clk_sys_in) disable iff (srst_in)
		(mode == MD_DISCRETE && run_a_eff && tick_a && !eq_a && !max_a)
			|=> (cif_a.count == $past(cif_a.count) + 8'h01);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count_a step wrong");

	// Reset zeroes both counters
	property p_reset_zero;
		@(posedge clk_sys_in)
		srst_in |=> (cif_a.count == CNT_RST && cif_b.count == CNT_RST);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("counters not zero");

	// A disabled pin stays low
	property p_pin_gate;
		@(posedge clk_sys_in) disable iff (srst_in)
		!out_en_b0_in |=> !out_b0_out;
	endproperty
	a_pin_gate: assert property (p_pin_gate) else $error("out_b0 driven");

	// Width match in B PWM drops the output
	property p_pwm_b_low;
		@(posedge clk_sys_in) disable iff (srst_in)
		(pwm_b && run_b_eff && tick_b && eq_h) |=> !st_r.tog_b ##1 (!out_b0_out && !out_b1_out);
	endproperty
	a_pwm_b_low: assert property (p_pwm_b_low) else $error("pwm high not ended");

	// Falling edge alone does not count in discrete mode
	property p_rise_only;
		@(posedge clk_sys_in) disable iff (srst_in)
		(mode == MD_DISCRETE && run_a_eff && fall_a && !rise_a)
			|=> (cif_a.count == $past(cif_a.count));
	endproperty
	a_rise_only: assert property (p_rise_only) else $error("count on falling edge");
endmodule : dtp_top

// ===== verif/dtp_pin_model.sv
// Count-clock pin model: clean pulses on the two timer count pins
`timescale 1ns/1ps
module dtp_pin_model (
	input wire logic clk_sys_in,
	output logic count_clk_a_out,
	output logic count_clk_b_out
);
	// Pins idle low outside pulse trains
	initial begin
		count_clk_a_out = 1'b0;
		count_clk_b_out = 1'b0;
	end

	// Pulses of three clocks high and six low, wider than the two-clock minimum
	// The trailing delay lets the counter and pins settle before anyone samples
	task automatic pulse(input bit sel_b, input int n);
		repeat (n) begin
			@(posedge clk_sys_in);
			if (sel_b) begin
				count_clk_b_out <= 1'b1;
			end else begin
				count_clk_a_out <= 1'b1;
			end
			repeat (3) @(posedge clk_sys_in);
			count_clk_a_out <= 1'b0;
			count_clk_b_out <= 1'b0;
			repeat (5) @(posedge clk_sys_in);
		end
		#1;
	endtask : pulse
endmodule : dtp_pin_model

// ===== verif/dtp_top_tb.sv
// Self-checking bench for the dual 8-bit timer pair
`timescale 1ns/1ps
`define CHK(got, exp) \
	begin \
		check_count++; \
		if ((got) !== (exp)) begin \
			n_errors++; \
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module dtp_top_tb;
	import dtp_pkg::*;
	logic clk_sys_in = 1'b0; // 100 MHz system clock
	logic srst_in = 1'b1; // Held for the first six cycles
	logic run_a = 1'b0;
	logic run_b = 1'b0;
	logic dual_edge_a = 1'b0; // Count A on both edges
	logic [3:0] mode_bits = MB_DISCRETE; // {a_hi, a_lo, b_hi, b_lo}
	logic out_en_a = 1'b0;
	logic out_en_b0 = 1'b0;
	logic out_en_b1 = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [2:0] reg_sel = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic out_a;
	logic out_b0;
	logic out_b1;
	logic irq_a;
	logic irq_b;
	logic cnt_clk_a; // Driven by the pin model
	logic cnt_clk_b;
	int n_errors = 0;
	int check_count = 0;
	int irq_a_n = 0; // Request pulses seen so far
	int irq_b_n = 0;

	// Clock generator
	always #5 clk_sys_in = ~clk_sys_in;

	// Count one-cycle request pulses
	always @(posedge clk_sys_in) begin
		if (irq_a === 1'b1) begin
			irq_a_n++;
		end
		if (irq_b === 1'b1) begin
			irq_b_n++;
		end
	end

	dtp_pin_model u_pins (
		.clk_sys_in(clk_sys_in),
		.count_clk_a_out(cnt_clk_a),
		.count_clk_b_out(cnt_clk_b)
	);

	dtp_top u_dut (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.count_clk_a_in(cnt_clk_a),
		.count_clk_b_in(cnt_clk_b),
		.run_a_in(run_a),
		.run_b_in(run_b),
		.dual_edge_a_in(dual_edge_a),
		.mode_a_hi_in(mode_bits[3]),
		.mode_a_lo_in(mode_bits[2]),
		.mode_b_hi_in(mode_bits[1]),
		.mode_b_lo_in(mode_bits[0]),
		.out_en_a_in(out_en_a),
		.out_en_b0_in(out_en_b0),
		.out_en_b1_in(out_en_b1),
		.reg_wr_in(reg_wr),
		.reg_rd_in(reg_rd),
		.reg_sel_in(reg_sel),
		.reg_wdata_in(reg_wdata),
		.reg_rdata_out(reg_rdata),
		.out_a_out(out_a),
		.out_b0_out(out_b0),
		.out_b1_out(out_b1),
		.irq_a_out(irq_a),
		.irq_b_out(irq_b)
	);

	// One byte write, strobe for one edge
	task automatic reg_write(input logic [2:0] sel, input logic [7:0] data);
		@(posedge clk_sys_in);
		reg_wr <= 1'b1;
		reg_sel <= sel;
		reg_wdata <= data;
		@(posedge clk_sys_in);
		reg_wr <= 1'b0;
	endtask : reg_write

	// One byte read, then compare against the expectation
	task automatic chk_reg(input logic [2:0] sel, input logic [7:0] exp);
		@(posedge clk_sys_in);
		reg_rd <= 1'b1;
		reg_sel <= sel;
		@(posedge clk_sys_in);
		reg_rd <= 1'b0;
		@(posedge clk_sys_in);
		#1;
		`CHK(reg_rdata, exp)
	endtask : chk_reg

	// Stop, pick a mode, load compares while stopped, then start
	task automatic setup(input logic [3:0] mode, input logic [7:0] ca, input logic [7:0] cb,
			input logic [7:0] hw, input logic ra);
		@(posedge clk_sys_in);
		run_a <= 1'b0;
		run_b <= 1'b0;
		mode_bits <= mode;
		reg_write(SEL_CMP_A, ca);
		reg_write(SEL_CMP_B, cb);
		reg_write(SEL_HW_B, hw);
		@(posedge clk_sys_in);
		run_a <= ra;
		run_b <= 1'b1;
	endtask : setup

	// Verdict and end of run
	task automatic tally_and_finish();
		if (n_errors == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// Watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk_sys_in);
		n_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		chk_reg(SEL_CNT_A, CNT_RST);
		chk_reg(SEL_CNT_B, CNT_RST);
		`CHK({out_a, out_b0, out_b1}, 3'b000)
		// Compare registers read back; counters and unmapped places refuse
		reg_write(SEL_CMP_A, 8'h5A);
		chk_reg(SEL_CMP_A, 8'h5A);
		reg_write(SEL_CNT_A, 8'h33);
		chk_reg(SEL_CNT_A, CNT_RST);
		chk_reg(3'h5, RD_UNMAPPED);
		// Discrete A, period of three ticks, one request
		setup(MB_DISCRETE, 8'h02, 8'h01, 8'h00, 1'b1);
		dual_edge_a <= 1'b1; // Ignored outside PWM, so falling edges must not count
		u_pins.pulse(1'b0, 2);
		chk_reg(SEL_CNT_A, 8'h02);
		u_pins.pulse(1'b0, 1);
		chk_reg(SEL_CNT_A, 8'h00);
		`CHK(irq_a_n, 1)
		// Discrete B matches at one, independent of A
		u_pins.pulse(1'b1, 1);
		chk_reg(SEL_CNT_B, 8'h01);
		u_pins.pulse(1'b1, 1);
		`CHK(irq_b_n, 1)
		chk_reg(SEL_CNT_B, 8'h00);
		// Stopping clears a part-way count
		u_pins.pulse(1'b0, 1);
		@(posedge clk_sys_in);
		run_a <= 1'b0;
		chk_reg(SEL_CNT_A, 8'h00);
		// Cascade: B carry moves A, a lone B match must not clear
		setup(MB_CASCADE, 8'h01, 8'h05, 8'h00, 1'b0);
		u_pins.pulse(1'b1, 256);
		chk_reg(SEL_CNT_A, 8'h01);
		chk_reg(SEL_CNT_B, 8'h00);
		u_pins.pulse(1'b1, 6);
		chk_reg(SEL_CNT_A, 8'h00);
		`CHK(irq_b_n, 2)
		`CHK(irq_a_n, 1)
		// Carrier: A clears on its own match
		setup(MB_CARRIER, 8'h01, 8'h03, 8'h06, 1'b1);
		out_en_b0 <= 1'b1;
		u_pins.pulse(1'b0, 2);
		chk_reg(SEL_CNT_A, 8'h00);
		// Low phase ends on match_b; carrier shows while A gate is open
		u_pins.pulse(1'b1, 4);
		`CHK(out_b0, 1'b1)
		`CHK(irq_b_n, 3)
		// A match closes the gate again
		u_pins.pulse(1'b0, 2);
		`CHK(out_b0, 1'b0)
		`CHK(irq_a_n, 3)
		// A free-running PWM toggles on every match
		setup(MB_A_PWM_B_DISC, 8'h03, 8'h00, 8'h00, 1'b1);
		out_en_a <= 1'b1;
		dual_edge_a <= 1'b0;
		u_pins.pulse(1'b0, 4);
		`CHK(out_a, 1'b1)
		u_pins.pulse(1'b0, 4);
		`CHK(out_a, 1'b0)
		// B pulse generator: high from match_b to high_width_b, routed pin
		setup(MB_A_DISC_B_PWM, 8'h00, 8'h02, 8'h05, 1'b0);
		out_en_b0 <= 1'b1;
		u_pins.pulse(1'b1, 3);
		`CHK({out_b0, out_b1}, 2'b10)
		u_pins.pulse(1'b1, 2);
		`CHK(out_b0, 1'b1)
		u_pins.pulse(1'b1, 1);
		`CHK(out_b0, 1'b0)
		chk_reg(SEL_CNT_B, 8'h00);
		@(posedge clk_sys_in);
		out_en_b0 <= 1'b0;
		out_en_b1 <= 1'b1;
		u_pins.pulse(1'b1, 3);
		`CHK({out_b0, out_b1}, 2'b01)
		chk_reg(SEL_CNT_B, 8'h03);
		// Mid-run reset zeroes a running count and the pins
		@(posedge clk_sys_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		chk_reg(SEL_CNT_B, CNT_RST);
		`CHK({out_a, out_b0, out_b1}, 3'b000)
		// Both PWM: A counts both edges, B high from match_b to high_width_b
		setup(MB_BOTH_PWM, 8'h02, 8'h01, 8'h03, 1'b1);
		dual_edge_a <= 1'b1;
		u_pins.pulse(1'b0, 1);
		chk_reg(SEL_CNT_A, 8'h02);
		u_pins.pulse(1'b0, 1);
		chk_reg(SEL_CNT_A, 8'h01);
		`CHK(out_a, 1'b1)
		u_pins.pulse(1'b1, 2);
		`CHK(out_b1, 1'b1)
		u_pins.pulse(1'b1, 2);
		`CHK(out_b1, 1'b0)
		// Prohibited pattern holds both counters at zero
		setup(4'hF, 8'h07, 8'h07, 8'h07, 1'b1);
		u_pins.pulse(1'b0, 2);
		u_pins.pulse(1'b1, 2);
		chk_reg(SEL_CNT_A, 8'h00);
		chk_reg(SEL_CNT_B, 8'h00);
		tally_and_finish();
	end
endmodule : dtp_top_tb
